// ### design/sav_pkg.sv
package sav_pkg;
    // Register byte offsets on the AHB-Lite slave
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_FEATURES = 8'h04;
    localparam logic [7:0] OFS_CYL_LO = 8'h08;
    localparam logic [7:0] OFS_CYL_HI = 8'h0c;
    localparam logic [7:0] OFS_COMMAND = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_ERROR = 8'h18;
    localparam logic [7:0] OFS_CTRL = 8'h1c;
    localparam logic [7:0] OFS_ATTR = 8'h20;

    // Command and key bytes
    localparam logic [7:0] CMD_SMART = 8'hb0;
    localparam logic [7:0] FEAT_READ_VALUES = 8'hd0;
    localparam logic [7:0] KEY_LO = 8'h4f;
    localparam logic [7:0] KEY_HI = 8'hc2;

    // Status and error bit positions
    localparam int ST_BSY = 7;
    localparam int ST_DRDY = 6;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int ER_ABRT = 2;

    // Control register bits
    localparam int CT_SMART_EN = 0;
    localparam int CT_MONITOR = 1;

    // Attribute register fields
    localparam int AT_SLOT_LSB = 0;
    localparam int AT_VAL_LSB = 8;
    localparam int AT_FLAG_LSB = 16;

    // Data structure layout, byte indices
    localparam logic [15:0] STRUCT_REV = 16'h0004;
    localparam int NUM_SLOTS = 30;
    localparam int SLOT_BYTES = 12;
    localparam logic [8:0] IDX_SLOTS = 9'h002;
    localparam logic [8:0] IDX_RSV0 = 9'h16a;
    localparam logic [8:0] IDX_CAP = 9'h170;
    localparam logic [8:0] IDX_VENDOR = 9'h182;
    localparam logic [7:0] LAST_WORD = 8'hff;
    localparam logic [3:0] OFF_ID = 4'h0;
    localparam logic [3:0] OFF_FLAG_LO = 4'h1;
    localparam logic [3:0] OFF_VALUE = 4'h3;

    // Attribute value encodings
    localparam logic [7:0] VAL_INIT = 8'h64;
    localparam logic [7:0] VAL_NOT_VALID = 8'hfe;
    localparam logic [7:0] VAL_BAD_LO = 8'h00;
    localparam logic [7:0] VAL_BAD_HI = 8'hff;
    // Flag bits kept: bit 0 and vendor bits 2..6; bit 1 and 7..15 reserved
    localparam logic [7:0] FLAG_KEEP = 8'h7d;

    // Settling time of the strap synchroniser before capture
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    typedef enum logic [2:0] {
        SAV_IDLE = 3'b001,
        SAV_SAVE = 3'b010,
        SAV_XFER = 3'b100
    } sav_state_t;
endpackage

// ### design/sav_readout.sv
`timescale 1ns/100ps
`default_nettype none
module sav_readout #(
    parameter int NUM_ATTR = 30,
    parameter logic [7:0] ID_BASE = 8'h01,
    parameter logic CMD_SUPPORTED = 1'b1,
    parameter logic CAP_PRE_POWER_SAVE = 1'b1,
    parameter logic CAP_AUTOSAVE = 1'b0,
    parameter logic [7:0] VENDOR_FILL = 8'h00
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic nv_save_req,
    input wire logic nv_save_done,
    input wire logic nv_smart_en,
    output logic smart_en_state,
    output logic intrq
);
    sav_pkg::sav_state_t state;
    logic [7:0] features;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic err_bit;
    logic abrt_bit;
    logic smart_en;
    logic monitor_on;
    logic dirty;
    logic [7:0] word_idx;
    logic [7:0] sum;
    logic [7:0] attr_val [sav_pkg::NUM_SLOTS];
    logic [7:0] attr_flag [sav_pkg::NUM_SLOTS];
    logic done_s1;
    logic done_s2;
    logic strap_s1;
    logic strap_s2;
    logic [1:0] strap_cnt;
    logic d_sel;
    logic d_write;
    logic [7:0] d_addr;
    logic addr_ok;
    logic [7:0] byte_lo;
    logic [7:0] byte_hi;
    logic [7:0] word_hi;
    logic data_pop;
    logic cmd_wr;
    logic cmd_ok;
    logic [7:0] status;
    logic [7:0] err_reg;
    logic [1:0] ctrl_reg;
    logic was_save;

    // Reported value: initial value until monitoring, reserved codes masked
    function automatic logic [7:0] report_val(input logic [7:0] v, input logic mon);
        logic [7:0] r;
        r = v;
        if (!mon) begin
            r = sav_pkg::VAL_INIT;
        end else if (v == sav_pkg::VAL_BAD_LO || v == sav_pkg::VAL_BAD_HI) begin
            r = sav_pkg::VAL_NOT_VALID;
        end
        return r;
    endfunction

    // One byte of the 512-byte structure, checksum byte excluded
    function automatic logic [7:0] struct_byte(input logic [8:0] b);
        logic [8:0] rel;
        logic [8:0] slot;
        logic [3:0] off;
        logic [7:0] r;
        rel = b - sav_pkg::IDX_SLOTS;
        slot = rel / 9'(sav_pkg::SLOT_BYTES);
        off = 4'(rel % 9'(sav_pkg::SLOT_BYTES));
        r = 8'h00;
        if (b < sav_pkg::IDX_SLOTS) begin
            r = b[0] ? sav_pkg::STRUCT_REV[15:8] : sav_pkg::STRUCT_REV[7:0];
        end else if (b < sav_pkg::IDX_RSV0) begin
            // Slots beyond the populated count stay all zero
            if (slot < 9'(NUM_ATTR)) begin
                unique case (off)
                    sav_pkg::OFF_ID: r = ID_BASE + slot[7:0];
                    sav_pkg::OFF_FLAG_LO: r = attr_flag[slot[4:0]] & sav_pkg::FLAG_KEEP;
                    sav_pkg::OFF_VALUE: r = report_val(attr_val[slot[4:0]], monitor_on);
                    default: r = 8'h00;
                endcase
            end
        end else if (b == sav_pkg::IDX_CAP) begin
            r = {6'h00, CAP_AUTOSAVE, CAP_PRE_POWER_SAVE};
        end else if (b >= sav_pkg::IDX_VENDOR) begin
            r = VENDOR_FILL;
        end
        return r;
    endfunction

    // Bus slave: always ready, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            d_sel <= 1'b0;
            d_write <= 1'b0;
            d_addr <= 8'h00;
        end else if (hready) begin
            d_sel <= hsel && htrans[1];
            d_write <= hwrite;
            d_addr <= haddr[7:0];
        end
    end

    assign addr_ok = hsel && htrans[1] && hready && !hwrite;
    assign data_pop = addr_ok && haddr[7:0] == sav_pkg::OFS_DATA && state == sav_pkg::SAV_XFER;
    assign cmd_wr = d_sel && d_write && d_addr == sav_pkg::OFS_COMMAND && state == sav_pkg::SAV_IDLE;
    // Every key byte, the enable and support must hold, else abort
    assign cmd_ok = CMD_SUPPORTED && smart_en && hwdata[7:0] == sav_pkg::CMD_SMART
        && features == sav_pkg::FEAT_READ_VALUES && cyl_lo == sav_pkg::KEY_LO
        && cyl_hi == sav_pkg::KEY_HI;

    always_comb begin
        status = 8'h00;
        status[sav_pkg::ST_BSY] = state == sav_pkg::SAV_SAVE;
        status[sav_pkg::ST_DRDY] = state != sav_pkg::SAV_SAVE;
        status[sav_pkg::ST_DRQ] = state == sav_pkg::SAV_XFER;
        status[sav_pkg::ST_ERR] = err_bit;
    end

    // Error and control read-back images, bits placed by name
    always_comb begin
        err_reg = 8'h00;
        err_reg[sav_pkg::ER_ABRT] = abrt_bit;
    end

    always_comb begin
        ctrl_reg = 2'h0;
        ctrl_reg[sav_pkg::CT_SMART_EN] = smart_en;
        ctrl_reg[sav_pkg::CT_MONITOR] = monitor_on;
    end

    // Low and high bytes of the word being handed out; a process rather than an
    // assign, so that attribute and monitor changes read inside the function wake it
    always_comb begin
        byte_lo = struct_byte({word_idx, 1'b0});
        byte_hi = struct_byte({word_idx, 1'b1});
    end
    // Final byte is the negated running sum so the block adds to zero
    assign word_hi = (word_idx == sav_pkg::LAST_WORD) ? 8'(8'h00 - sum - byte_lo) : byte_hi;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok) begin
            unique case (haddr[7:0])
                sav_pkg::OFS_DATA: hrdata <= data_pop ? {16'h0000, word_hi, byte_lo} : 32'h0000_0000;
                sav_pkg::OFS_FEATURES: hrdata <= {24'h000000, features};
                sav_pkg::OFS_CYL_LO: hrdata <= {24'h000000, cyl_lo};
                sav_pkg::OFS_CYL_HI: hrdata <= {24'h000000, cyl_hi};
                sav_pkg::OFS_STATUS: hrdata <= {24'h000000, status};
                sav_pkg::OFS_ERROR: hrdata <= {24'h000000, err_reg};
                sav_pkg::OFS_CTRL: hrdata <= {30'h00000000, ctrl_reg};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Taskfile input registers; frozen while the device is busy
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            features <= 8'h00;
            cyl_lo <= 8'h00;
            cyl_hi <= 8'h00;
        end else if (d_sel && d_write && state == sav_pkg::SAV_IDLE) begin
            if (d_addr == sav_pkg::OFS_FEATURES) begin
                features <= hwdata[7:0];
            end
            if (d_addr == sav_pkg::OFS_CYL_LO) begin
                cyl_lo <= hwdata[7:0];
            end
            if (d_addr == sav_pkg::OFS_CYL_HI) begin
                cyl_hi <= hwdata[7:0];
            end
        end
    end

    // Synchronisers for the save acknowledge and the enable strap
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
            strap_s1 <= 1'b0;
            strap_s2 <= 1'b0;
        end else begin
            done_s1 <= nv_save_done;
            done_s2 <= done_s1;
            strap_s1 <= nv_smart_en;
            strap_s2 <= strap_s1;
        end
    end

    // Enable state comes back from NV storage after reset, then software owns it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_cnt <= 2'h0;
            smart_en <= 1'b0;
            monitor_on <= 1'b0;
        end else begin
            if (strap_cnt != sav_pkg::STRAP_WAIT) begin
                strap_cnt <= strap_cnt + 2'h1;
                smart_en <= strap_s2;
            end else if (d_sel && d_write && d_addr == sav_pkg::OFS_CTRL) begin
                smart_en <= hwdata[sav_pkg::CT_SMART_EN];
            end
            // Monitoring may only begin once SMART is enabled
            if (!smart_en) begin
                monitor_on <= 1'b0;
            end else if (d_sel && d_write && d_addr == sav_pkg::OFS_CTRL && hwdata[sav_pkg::CT_MONITOR]) begin
                monitor_on <= 1'b1;
            end
        end
    end

    assign smart_en_state = smart_en;

    // Attribute store, updated by the monitoring firmware
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < sav_pkg::NUM_SLOTS; i++) begin
                attr_val[i] <= sav_pkg::VAL_INIT;
                attr_flag[i] <= 8'h00;
            end
        end else if (d_sel && d_write && d_addr == sav_pkg::OFS_ATTR && monitor_on) begin
            for (int i = 0; i < sav_pkg::NUM_SLOTS; i++) begin
                if (hwdata[sav_pkg::AT_SLOT_LSB +: 5] == 5'(i)) begin
                    attr_val[i] <= hwdata[sav_pkg::AT_VAL_LSB +: 8];
                    attr_flag[i] <= hwdata[sav_pkg::AT_FLAG_LSB +: 8];
                end
            end
        end
    end

    // Command sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= sav_pkg::SAV_IDLE;
            err_bit <= 1'b0;
            abrt_bit <= 1'b0;
            nv_save_req <= 1'b0;
            word_idx <= 8'h00;
            sum <= 8'h00;
        end else begin
            unique case (state)
                sav_pkg::SAV_IDLE: begin
                    if (cmd_wr) begin
                        err_bit <= !cmd_ok;
                        abrt_bit <= !cmd_ok;
                        word_idx <= 8'h00;
                        sum <= 8'h00;
                        if (cmd_ok) begin
                            state <= sav_pkg::SAV_SAVE;
                            nv_save_req <= dirty;
                        end
                    end
                end
                sav_pkg::SAV_SAVE: begin
                    // BSY holds until storage confirms a requested save (one cycle if none was requested), then DRQ rises as BSY falls
                    if (!nv_save_req || done_s2) begin
                        nv_save_req <= 1'b0;
                        state <= sav_pkg::SAV_XFER;
                    end
                end
                sav_pkg::SAV_XFER: begin
                    if (data_pop) begin
                        word_idx <= word_idx + 8'h01;
                        sum <= 8'(sum + byte_lo + byte_hi);
                        if (word_idx == sav_pkg::LAST_WORD) begin
                            state <= sav_pkg::SAV_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Dirty marks values changed since the last save; a new update wins over the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dirty <= 1'b0;
        end else if (d_sel && d_write && d_addr == sav_pkg::OFS_ATTR && monitor_on) begin
            dirty <= 1'b1;
        end else if (state == sav_pkg::SAV_SAVE && nv_save_req && done_s2) begin
            dirty <= 1'b0;
        end
    end

    // High in each cycle after one spent in the save state, up to the first cycle after the sequencer has left it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            was_save <= 1'b0;
        end else begin
            was_save <= state == sav_pkg::SAV_SAVE;
        end
    end

    // Interrupt one cycle after DRQ rises as BSY falls, also on abort; cleared by status read or command write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            intrq <= 1'b0;
        end else if ((state == sav_pkg::SAV_XFER && was_save) || (cmd_wr && !cmd_ok)) begin
            intrq <= 1'b1;
        end else if ((addr_ok && haddr[7:0] == sav_pkg::OFS_STATUS) || cmd_wr) begin
            intrq <= 1'b0;
        end
    end
endmodule // sav_readout
`default_nettype wire

// ### testbench/sav_readout_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module sav_readout_asserts (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic nv_save_req,
    input wire logic nv_save_done,
    input wire logic smart_en_state,
    input wire logic intrq
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic take;
    logic st_rd;
    logic [2:0] cmd_hist;
    assign take = hsel && htrans[1] && hready;
    assign st_rd = take && !hwrite && haddr[7:0] == sav_pkg::OFS_STATUS;
    // Bit 0 marks the data phase of a command write, upper bits its age
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_hist <= 3'h0;
        end else begin
            cmd_hist <= {cmd_hist[1:0], take && hwrite && haddr[7:0] == sav_pkg::OFS_COMMAND};
        end
    end
    sequence s_cmd_off;
        cmd_hist[0] && !smart_en_state;
    endsequence
    sequence s_abort_flag;
        intrq && !nv_save_req;
    endsequence
    property p_abort;
        s_cmd_off |-> ##[1:3] s_abort_flag;
    endproperty
    a_abort: assert property (p_abort) else $error("disabled command not aborted");
    property p_save_after_cmd;
        $rose(nv_save_req) |-> |cmd_hist;
    endproperty
    a_save_after_cmd: assert property (p_save_after_cmd) else $error("save without command");
    property p_req_hold;
        nv_save_req && !nv_save_done |=> nv_save_req;
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("save dropped early");
    property p_intrq_after_save;
        $fell(nv_save_req) |-> ##[0:2] intrq;
    endproperty
    a_intrq_after_save: assert property (p_intrq_after_save) else $error("no interrupt after save");
    property p_intrq_quiet;
        $rose(intrq) |-> !$past(nv_save_req);
    endproperty
    a_intrq_quiet: assert property (p_intrq_quiet) else $error("interrupt during save");
    property p_en_save;
        nv_save_req |-> smart_en_state;
    endproperty
    a_en_save: assert property (p_en_save) else $error("save while disabled");
    property p_bus_ok;
        hreadyout && !hresp;
    endproperty
    a_bus_ok: assert property (p_bus_ok) else $error("bus stalled or error");
    property p_intrq_clear;
        $fell(intrq) |-> $past(st_rd) || $past(st_rd, 2);
    endproperty
    a_intrq_clear: assert property (p_intrq_clear) else $error("interrupt cleared unasked");
endmodule // sav_readout_asserts
`default_nettype wire

// ### testbench/sav_nv_model.sv
`timescale 1ns/100ps
`default_nettype none
module sav_nv_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic nv_save_req,
    input wire logic smart_en_state,
    input wire logic [7:0] delay,
    output logic nv_save_done,
    output logic nv_smart_en
);
    logic [7:0] cnt;
    logic [2:0] up;
    logic persisted = 1'b0;
    assign nv_smart_en = persisted;
    // Persisted flag ignores reset; wait for the strap load before tracking
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            up <= 3'h0;
        end else if (up != 3'h7) begin
            up <= up + 3'h1;
        end else begin
            persisted <= smart_en_state;
        end
    end
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn || !nv_save_req) begin
            cnt <= 8'h00;
            nv_save_done <= 1'b0;
        end else if (cnt == delay) begin
            nv_save_done <= 1'b1;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule // sav_nv_model
`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; $display("Error %s exp %h got %h", nm, e, g); end end
module testbench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0] delay = 8'h00;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, nv_save_req, nv_save_done, nv_smart_en, smart_en_state, intrq;
    logic [7:0] exp_b [512];
    logic [7:0] ev [3];
    logic [7:0] ef [3];
    int num_errors = 0;
    int check_count = 0;
    int saves = 0;
    always #20 hclk = ~hclk;
    always @(posedge nv_save_req) saves++;
    sav_readout #(.NUM_ATTR(3)) sav_readout_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .nv_save_req(nv_save_req), .nv_save_done(nv_save_done),
        .nv_smart_en(nv_smart_en), .smart_en_state(smart_en_state), .intrq(intrq));
    sav_nv_model sav_nv_model_i (.hclk(hclk), .hresetn(hresetn), .nv_save_req(nv_save_req),
        .smart_en_state(smart_en_state), .delay(delay), .nv_save_done(nv_save_done), .nv_smart_en(nv_smart_en));
    task automatic close_out;
        if (num_errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wait_for(input logic s);
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while ((s ? intrq : hreadyout) !== 1'b1 && n < 300);
        if ((s ? intrq : hreadyout) !== 1'b1) begin
            num_errors++;
            close_out;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wait_for(1'b0);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_for(1'b0);
        rd = hrdata;
    endtask
    task automatic cmd(input logic [7:0] f, input logic [7:0] lo, input logic [7:0] hi);
        bus(1'b1, sav_pkg::OFS_FEATURES, {24'h0, f});
        bus(1'b1, sav_pkg::OFS_CYL_LO, {24'h0, lo});
        bus(1'b1, sav_pkg::OFS_CYL_HI, {24'h0, hi});
        bus(1'b1, sav_pkg::OFS_COMMAND, {24'h0, sav_pkg::CMD_SMART});
        wait_for(1'b1);
    endtask
    task automatic expect_abort(input logic [7:0] f, input logic [7:0] lo, input logic [7:0] hi);
        cmd(f, lo, hi);
        bus(1'b0, sav_pkg::OFS_STATUS, 32'h0);
        `CHK("abort err", 2'b01, {rd[sav_pkg::ST_DRQ], rd[sav_pkg::ST_ERR]})
        bus(1'b0, sav_pkg::OFS_ERROR, 32'h0);
        `CHK("abort code", 1'b1, rd[sav_pkg::ER_ABRT])
        `CHK("irq cleared", 1'b0, intrq)
    endtask
    // Expected image of the structure, low byte of each field first
    task automatic read_block;
        logic [7:0] sum;
        sum = 8'h00;
        for (int i = 0; i < 512; i++) exp_b[i] = 8'h00;
        exp_b[0] = 8'h04;
        for (int i = 0; i < 3; i++) begin
            exp_b[2 + 12 * i] = 8'h01 + i[7:0];
            exp_b[3 + 12 * i] = ef[i];
            exp_b[5 + 12 * i] = ev[i];
        end
        exp_b[368] = 8'h01;
        for (int i = 0; i < 511; i++) sum += exp_b[i];
        exp_b[511] = 8'h00 - sum;
        cmd(8'hd0, 8'h4f, 8'hc2);
        bus(1'b0, sav_pkg::OFS_STATUS, 32'h0);
        `CHK("drq up", 2'b01, {rd[sav_pkg::ST_BSY], rd[sav_pkg::ST_DRQ]})
        for (int w = 0; w < 256; w++) begin
            bus(1'b0, sav_pkg::OFS_DATA, 32'h0);
            `CHK("word", {exp_b[2 * w + 1], exp_b[2 * w]}, rd[15:0])
        end
        bus(1'b0, sav_pkg::OFS_STATUS, 32'h0);
        `CHK("drq end", 1'b0, rd[sav_pkg::ST_DRQ])
    endtask
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (6) @(posedge hclk);
        `CHK("en reset", 1'b0, smart_en_state)
        bus(1'b0, sav_pkg::OFS_STATUS, 32'h0);
        `CHK("status", 8'h40, rd[7:0])
        bus(1'b0, 8'h3c, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        expect_abort(8'hd0, 8'h4f, 8'hc2);
        bus(1'b1, sav_pkg::OFS_CTRL, 32'h1);
        expect_abort(8'hd1, 8'h4f, 8'hc2);
        expect_abort(8'hd0, 8'h4e, 8'hc2);
        expect_abort(8'hd0, 8'h4f, 8'hc3);
        `CHK("en set", 1'b1, smart_en_state)
        bus(1'b1, sav_pkg::OFS_ATTR, 32'h0000_1000);
        ev = '{8'h64, 8'h64, 8'h64};
        ef = '{8'h00, 8'h00, 8'h00};
        read_block;
        bus(1'b1, sav_pkg::OFS_CTRL, 32'h3);
        bus(1'b1, sav_pkg::OFS_ATTR, 32'h00ff_0000);
        bus(1'b1, sav_pkg::OFS_ATTR, 32'h0001_4201);
        bus(1'b1, sav_pkg::OFS_ATTR, 32'h0000_ff02);
        delay <= 8'h14;
        ev = '{8'hfe, 8'h42, 8'hfe};
        ef = '{8'h7d, 8'h01, 8'h00};
        read_block;
        `CHK("saves", 1, saves)
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (6) @(posedge hclk);
        `CHK("en kept", 1'b1, smart_en_state)
        close_out;
    end
    initial begin
        repeat (20000) @(posedge hclk);
        num_errors++;
        close_out;
    end
endmodule // testbench
bind sav_readout sav_readout_asserts sav_readout_asserts_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .nv_save_req(nv_save_req), .nv_save_done(nv_save_done), .smart_en_state(smart_en_state), .intrq(intrq));
`default_nettype wire
